// >>> logic/lrc_ladder_reference_control.sv
// Control register and tap selection of the ladder voltage reference.
// Assumes synchronous register port strobes and synchronous pin direction input.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// [RQ1] Sixteen taps picked by four-bit code
// [RQ2] Low range: level is code over 24
// [RQ3] High range: quarter plus code over 32
// [RQ4] Bit 7 powers the ladder
// [RQ5] Bit 6 routes level to pin
// [RQ6] Bit 5 one means low range
// [RQ7] Bit 4 reads zero; bits 3-0 tap
// [RQ8] Reset clears power and pin drive
// [RQ9] Reset clears range and tap code
// [RQ10] Wake from sleep keeps register contents
// [RQ11] Pin driven only if direction is input
// [RQ12] Comparator settings never gate the reference
// [RQ13] Software waits settling after level changes
// [RQ14] Software may power down before sleep
// [RQ15] Comparator mode 010 takes internal reference
// [RQ16] Power off forces enable and pin off
module lrc_ladder_reference_control (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [7:0] regRdData,
	input wire logic pin2DirectionBit,
	input wire logic [2:0] comparatorConfig,
	input wire logic sleepWake,
	output logic ladderPowerOn,
	output logic analogOutPinConnect,
	output logic lowRange,
	output logic [3:0] tapCode,
	output logic [7:0] refNumerator,
	output logic [7:0] refDenominator,
	output logic comparatorUsesRef
);
	logic [7:0] refCtrl_reg;
	logic [7:0] refCtrl_next;
	logic hit;

	// Level as a fraction of supply, numerator over denominator
	function automatic logic [7:0] level_num(input logic low, input logic [3:0] code);
		level_num = low ? {4'h0, code} : 8'(lrc_pkg::HIGH_RANGE_BASE + {4'h0, code}); // [RQ2] [RQ3]
	endfunction

	assign hit = (regAddr == lrc_pkg::REF_CTRL_OFFSET);

	always_comb begin
		refCtrl_next = refCtrl_reg;
		if (regWrStrobe && hit) begin
			refCtrl_next = regWrData & lrc_pkg::WRITE_MASK; // [RQ7]
		end
	end

	// Wake from sleep is not a reset, so it has no path into this register
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			refCtrl_reg <= lrc_pkg::REF_CTRL_RESET; // [RQ8] [RQ9]
		end else if (clkEn) begin
			refCtrl_reg <= refCtrl_next; // [RQ10]
		end
	end

	// Unmapped addresses read zero
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData <= 8'h00;
		end else if (clkEn) begin
			regRdData <= (regRdStrobe && hit) ? refCtrl_reg : 8'h00;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ladderPowerOn <= 1'b0;
			analogOutPinConnect <= 1'b0;
			lowRange <= 1'b0;
			tapCode <= 4'h0;
			refNumerator <= 8'h00;
			refDenominator <= lrc_pkg::HIGH_RANGE_DIV;
			comparatorUsesRef <= 1'b0;
		end else if (clkEn) begin
			ladderPowerOn <= refCtrl_reg[lrc_pkg::POWER_BIT]; // [RQ4] [RQ16] [RQ12]
			analogOutPinConnect <= refCtrl_reg[lrc_pkg::POWER_BIT] && refCtrl_reg[lrc_pkg::PIN_DRIVE_BIT]
				&& pin2DirectionBit; // [RQ5] [RQ11] [RQ16]
			lowRange <= refCtrl_reg[lrc_pkg::LOW_RANGE_BIT]; // [RQ6]
			tapCode <= refCtrl_reg[lrc_pkg::TAP_MSB:0]; // [RQ1]
			refNumerator <= level_num(refCtrl_reg[lrc_pkg::LOW_RANGE_BIT], refCtrl_reg[lrc_pkg::TAP_MSB:0]);
			refDenominator <= refCtrl_reg[lrc_pkg::LOW_RANGE_BIT] ? lrc_pkg::LOW_RANGE_DIV
				: lrc_pkg::HIGH_RANGE_DIV; // [RQ2] [RQ3]
			comparatorUsesRef <= (comparatorConfig == lrc_pkg::CMP_INTERNAL_REF_MODE); // [RQ15]
		end
	end

	property p_reset_clear;
		@(posedge clk_sys) $rose(sys_rst) |-> ##1 (refCtrl_reg == 8'h00);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("control not cleared by reset"); // [RQ8]

	property p_bit4_zero;
		@(posedge clk_sys) disable iff (sys_rst) refCtrl_reg[4] == 1'b0;
	endproperty
	a_bit4_zero: assert property (p_bit4_zero) else $error("unused bit set"); // [RQ7]

	sequence s_write;
		clkEn && regWrStrobe && hit;
	endsequence
	property p_write_store;
		@(posedge clk_sys) disable iff (sys_rst) s_write |=> (refCtrl_reg == ($past(regWrData) & 8'hef));
	endproperty
	a_write_store: assert property (p_write_store) else $error("write not stored"); // [RQ7]

	property p_hold;
		@(posedge clk_sys) disable iff (sys_rst) !(regWrStrobe && hit) |=> $stable(refCtrl_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("control changed without write"); // [RQ10]

	property p_power;
		@(posedge clk_sys) disable iff (sys_rst) clkEn |=> ladderPowerOn == $past(refCtrl_reg[7]);
	endproperty
	a_power: assert property (p_power) else $error("power output wrong"); // [RQ4]

	property p_pin_gate;
		@(posedge clk_sys) disable iff (sys_rst)
			$past(clkEn) && analogOutPinConnect |-> ladderPowerOn && $past(pin2DirectionBit);
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin driven while gated"); // [RQ11]

	property p_pin_on;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn && refCtrl_reg[7] && refCtrl_reg[6] && pin2DirectionBit |=> analogOutPinConnect;
	endproperty
	a_pin_on: assert property (p_pin_on) else $error("pin not connected"); // [RQ5]

	property p_range;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn |=> refDenominator == ($past(refCtrl_reg[5]) ? 8'h18 : 8'h20);
	endproperty
	a_range: assert property (p_range) else $error("range divisor wrong"); // [RQ6]

	property p_high_num;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn && !refCtrl_reg[5] |=> refNumerator == 8'(8'h08 + $past(refCtrl_reg[3:0]));
	endproperty
	a_high_num: assert property (p_high_num) else $error("high range level wrong"); // [RQ3]

	property p_cmp;
		@(posedge clk_sys) disable iff (sys_rst) clkEn |=> comparatorUsesRef == ($past(comparatorConfig) == 3'h2);
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparator routing wrong"); // [RQ15]

	// Write edge, then one enabled edge to reach the outputs
	sequence s_write_settled;
		s_write ##1 clkEn;
	endsequence

	// Comparator mode moving with no register write in the same cycle
	sequence s_cmp_move;
		$changed(comparatorConfig) && !(regWrStrobe && hit);
	endsequence

	property p_low_num;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn && refCtrl_reg[lrc_pkg::LOW_RANGE_BIT]
			|=> refNumerator == {4'h0, $past(refCtrl_reg[lrc_pkg::TAP_MSB:0])};
	endproperty
	a_low_num: assert property (p_low_num) else $error("low range level wrong"); // [RQ2]

	property p_range_out;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn
			|=> lowRange == $past(refCtrl_reg[lrc_pkg::LOW_RANGE_BIT]);
	endproperty
	a_range_out: assert property (p_range_out) else $error("range output wrong"); // [RQ6]

	property p_tap_out;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn
			|=> tapCode == $past(refCtrl_reg[lrc_pkg::TAP_MSB:0]);
	endproperty
	a_tap_out: assert property (p_tap_out) else $error("tap output wrong"); // [RQ1]

	// Highest level is base plus the top code, never beyond
	property p_num_max;
		@(posedge clk_sys) disable iff (sys_rst)
			refNumerator <= 8'h17;
	endproperty
	a_num_max: assert property (p_num_max) else $error("level numerator out of range"); // [RQ1]

	property p_den_legal;
		@(posedge clk_sys) disable iff (sys_rst)
			(refDenominator == lrc_pkg::LOW_RANGE_DIV) || (refDenominator == lrc_pkg::HIGH_RANGE_DIV);
	endproperty
	a_den_legal: assert property (p_den_legal) else $error("level denominator illegal"); // [RQ2] [RQ3]

	property p_power_gate;
		@(posedge clk_sys) disable iff (sys_rst)
			!ladderPowerOn
			|-> !analogOutPinConnect;
	endproperty
	a_power_gate: assert property (p_power_gate) else $error("pin driven while powered down"); // [RQ16]

	property p_pin_off;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn && !refCtrl_reg[lrc_pkg::PIN_DRIVE_BIT]
			|=> !analogOutPinConnect;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin driven without drive bit"); // [RQ5]

	property p_wake_keep;
		@(posedge clk_sys) disable iff (sys_rst)
			sleepWake && !(regWrStrobe && hit)
			|=> $stable(refCtrl_reg);
	endproperty
	a_wake_keep: assert property (p_wake_keep) else $error("wake changed control"); // [RQ10]

	property p_read_data;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn && regRdStrobe && hit
			|=> regRdData == $past(refCtrl_reg);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data wrong"); // [RQ7]

	property p_read_unmapped;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn && regRdStrobe && !hit
			|=> regRdData == 8'h00;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero"); // [RQ7]

	// Read data stands one cycle only, so an idle port reads zero
	property p_read_idle;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn && !regRdStrobe
			|=> regRdData == 8'h00;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data lingered"); // [RQ7]

	property p_freeze;
		@(posedge clk_sys) disable iff (sys_rst)
			!clkEn
			|=> $stable(refCtrl_reg) && $stable(regRdData) && $stable(ladderPowerOn);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // [RQ10]

	// Two reset edges needed: outputs are unknown before the first one
	property p_reset_outputs;
		@(posedge clk_sys)
			sys_rst && $past(sys_rst)
			|-> !ladderPowerOn && !analogOutPinConnect && !lowRange && (tapCode == 4'h0);
	endproperty
	a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared in reset"); // [RQ8]

	property p_reset_reg;
		@(posedge clk_sys)
			sys_rst && $past(sys_rst)
			|-> (refCtrl_reg == lrc_pkg::REF_CTRL_RESET) && (refDenominator == lrc_pkg::HIGH_RANGE_DIV);
	endproperty
	a_reset_reg: assert property (p_reset_reg) else $error("control not reset"); // [RQ9]

	property p_write_to_out;
		@(posedge clk_sys) disable iff (sys_rst)
			s_write_settled
			|=> ladderPowerOn == $past(regWrData[lrc_pkg::POWER_BIT], 2);
	endproperty
	a_write_to_out: assert property (p_write_to_out) else $error("written power bit not seen"); // [RQ4]

	property p_write_to_tap;
		@(posedge clk_sys) disable iff (sys_rst)
			s_write_settled
			|=> tapCode == $past(regWrData[lrc_pkg::TAP_MSB:0], 2);
	endproperty
	a_write_to_tap: assert property (p_write_to_tap) else $error("written tap code not seen"); // [RQ1]

	// Comparator mode must never disturb the reference settings
	property p_cmp_independent;
		@(posedge clk_sys) disable iff (sys_rst)
			s_cmp_move
			|=> $stable(refCtrl_reg);
	endproperty
	a_cmp_independent: assert property (p_cmp_independent) else $error("comparator mode moved control"); // [RQ12]

	property p_den_high;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn && !refCtrl_reg[lrc_pkg::LOW_RANGE_BIT]
			|=> refDenominator == lrc_pkg::HIGH_RANGE_DIV;
	endproperty
	a_den_high: assert property (p_den_high) else $error("high range divisor wrong"); // [RQ3]

	property p_pin_follow_dir;
		@(posedge clk_sys) disable iff (sys_rst)
			clkEn && !pin2DirectionBit
			|=> !analogOutPinConnect;
	endproperty
	a_pin_follow_dir: assert property (p_pin_follow_dir) else $error("pin driven while output"); // [RQ11]
endmodule
`default_nettype wire

// >>> logic/lrc_pkg.sv
// Constants for the ladder reference control block.
// Assumes an 8-bit register port, one clock, active-high async reset.
package lrc_pkg;
	localparam logic [7:0] REF_CTRL_OFFSET = 8'h9f;
	localparam logic [7:0] REF_CTRL_RESET = 8'h00;
	localparam int POWER_BIT = 7;
	localparam int PIN_DRIVE_BIT = 6;
	localparam int LOW_RANGE_BIT = 5;
	localparam int UNUSED_BIT = 4;
	localparam int TAP_MSB = 3;
	localparam int TAP_WIDTH = 4;
	localparam int TAP_COUNT = 16;
	localparam logic [3:0] TAP_MAX = 4'hf;
	localparam logic [7:0] LOW_RANGE_DIV = 8'h18;
	localparam logic [7:0] HIGH_RANGE_DIV = 8'h20;
	localparam logic [7:0] HIGH_RANGE_BASE = 8'h08;
	localparam logic [2:0] CMP_INTERNAL_REF_MODE = 3'h2;
	localparam logic [7:0] WRITE_MASK = 8'hef;
endpackage

// >>> sim/lrc_ladder_reference_control_bench.sv
// Self-checking bench for the ladder reference control block.
// Assumes register port with read data one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module lrc_ladder_reference_control_bench;
	logic clk_sys = 0, sys_rst = 1, clkEn = 1, regWrStrobe = 0, regRdStrobe = 0, pin2DirectionBit = 1, sleepWake = 0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, refNumerator, refDenominator;
	logic [2:0] comparatorConfig = 3'h0;
	logic [3:0] tapCode;
	logic ladderPowerOn, analogOutPinConnect, lowRange, comparatorUsesRef;
	int n_errors = 0, checks_done = 0;
	lrc_ladder_reference_control u_lrc_ladder_reference_control (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
		.regRdStrobe(regRdStrobe), .regRdData(regRdData), .pin2DirectionBit(pin2DirectionBit),
		.comparatorConfig(comparatorConfig), .sleepWake(sleepWake), .ladderPowerOn(ladderPowerOn),
		.analogOutPinConnect(analogOutPinConnect), .lowRange(lowRange), .tapCode(tapCode),
		.refNumerator(refNumerator), .refDenominator(refDenominator), .comparatorUsesRef(comparatorUsesRef));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	// Outputs lag the register by one more edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge clk_sys);
		regWrStrobe <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge clk_sys);
		regRdStrobe <= 1'b0;
		#1;
		`CHK(regRdData, exp)
	endtask
	task automatic outs(input logic [22:0] e);
		`CHK({ladderPowerOn, analogOutPinConnect, lowRange, tapCode, refNumerator, refDenominator}, e)
	endtask
	task automatic settle;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#20000;
		n_errors++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		outs({3'b000, 4'h0, 8'h00, 8'h20});
		rd(8'h9f, 8'h00);
		wr(8'h9f, 8'hb6);
		outs({3'b101, 4'h6, 8'h06, 8'h18});
		rd(8'h9f, 8'ha6);
		$display("test basic done");
		for (int i = 0; i < 16; i++) begin
			wr(8'h9f, 8'hc0 | 8'(i));
			outs({3'b110, i[3:0], 8'(i + 8), 8'h20});
		end
		@(posedge clk_sys);
		pin2DirectionBit <= 1'b0;
		settle;
		`CHK(analogOutPinConnect, 1'b0)
		@(posedge clk_sys);
		pin2DirectionBit <= 1'b1;
		wr(8'h9f, 8'h4f);
		outs({3'b000, 4'hf, 8'h17, 8'h20});
		$display("test taps done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			comparatorConfig <= 3'(i);
			settle;
			`CHK(comparatorUsesRef, (i == 2) ? 1'b1 : 1'b0)
			`CHK(tapCode, 4'hf)
		end
		@(posedge clk_sys);
		sleepWake <= 1'b1;
		@(posedge clk_sys);
		sleepWake <= 1'b0;
		rd(8'h9f, 8'h4f);
		// Unmapped and frozen accesses must leave the register alone
		wr(8'h1f, 8'hff);
		rd(8'h1f, 8'h00);
		@(posedge clk_sys);
		clkEn <= 1'b0;
		wr(8'h9f, 8'h21);
		@(posedge clk_sys);
		clkEn <= 1'b1;
		rd(8'h9f, 8'h4f);
		wr(8'h9f, 8'hff);
		rd(8'h9f, 8'hef);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		#1;
		outs({3'b000, 4'h0, 8'h00, 8'h20});
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(8'h9f, 8'h00);
		$display("test misc done");
		report_and_stop;
	end
endmodule
`default_nettype wire
